/* File: core/tap_regs.svh */
/*
  Constants for the test access port: instruction codes, chain layout and
  register widths. Assumes it is included by bare name, definitions only.
*/
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define IR_W          3
`define IR_EXTEST     3'h0
`define IR_IDCODE     3'h1
`define IR_SAMPLE     3'h2
`define IR_CLAMP      3'h3
`define IR_BYPASS     3'h7
// fixed pattern loaded into the instruction shifter on capture
`define IR_CAPTURE    3'h1

// ----------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------
`define CHAIN_LEN     77
`define ID_W          32
// one bit per chain cell, bit n-1 for cell n; set means output-type cell
`define OUT_CELL_MASK 77'h1_2555_5460_08b7_b16f_606
// consecutive tms-high edges that force test-logic-reset from anywhere
`define TMS_RESET_EDGES 3'h5
// mclk edges after reset before the pin synchroniser and the tck edge register both hold real levels
`define TCK_SETTLE    2'h3

`endif

/* File: core/tap_pkg.sv */
/*
  Types shared by the test access port files.
  Assumes tap_regs.svh supplies the numeric constants.
*/
package tap_pkg;

  // ----------------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_t;

  // ----------------------------------------------------------------------
  // pin groups
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } jtag_out_t;

endpackage

/* File: core/sync2.sv */
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,  // system clock
  input  wire logic         reset, // synchronous, active high
  input  wire logic         en,    // clock enable
  input  wire logic [W-1:0] d,     // asynchronous input
  output logic      [W-1:0] q      // synchronised output
);

  logic [W-1:0] meta_reg;

  if (W < 1) begin
    $error("sync2: W must be at least 1");
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (en) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

/* File: core/jtag_tap_boundary_scan.sv */
/*
  Test access port: sixteen-state controller, 3-bit instruction register,
  boundary chain with latched parallel outputs, single-bit passthrough and
  identification register. Assumes tck/tms/tdi arrive asynchronously and
  are oversampled by mclk, which must run well above tck (bench: 40 MHz
  against 5 MHz).
*/
`timescale 1ns/100ps
`include "tap_regs.svh"

module jtag_tap_boundary_scan
  import tap_pkg::*;
#(
  parameter int          CHAIN_LEN = `CHAIN_LEN,
  parameter logic [31:0] ID_VALUE  = 32'h1234_5679  // arbitrary value, bit 0 set
) (
  input  wire logic                 mclk,       // system clock, 40 MHz
  input  wire logic                 reset,      // synchronous, active high
  input  wire logic                 clk_en,     // freezes all state when low
  input  wire jtag_in_t             jtag_in,    // tck, tms, tdi pins
  output jtag_out_t                 jtag_out,   // tdo and its enable (low drives)
  input  wire logic [CHAIN_LEN-1:0] cell_obs,   // pin levels seen by each cell
  input  wire logic [CHAIN_LEN-1:0] core_drive, // values normal logic drives
  output logic      [CHAIN_LEN-1:0] cell_drive, // values to the output pins
  output logic                      test_active // pins under boundary control
);

  // ----------------------------------------------------------------------
  // pin synchronisation and tck edge detection
  // ----------------------------------------------------------------------
  jtag_in_t             pins_s;
  logic [CHAIN_LEN-1:0] obs_s;
  logic                 tck_d_reg;

  if (CHAIN_LEN != `CHAIN_LEN) begin
    $error("chain length must match the cell map");
  end
  if (ID_VALUE[0] != 1'b1) begin
    $error("identification bit 0 must be one");
  end

  sync2 #(.W($bits(jtag_in_t))) u_pin_sync (
    .mclk  (mclk),
    .reset (reset),
    .en    (clk_en),
    .d     (jtag_in),
    .q     (pins_s)
  );

  // input and output cells of a bidirectional pin observe the same level
  sync2 #(.W(CHAIN_LEN)) u_obs_sync (
    .mclk  (mclk),
    .reset (reset),
    .en    (clk_en),
    .d     (cell_obs),
    .q     (obs_s)
  );

  always_ff @(posedge mclk) begin
    if (reset) tck_d_reg <= 1'b0;
    else if (clk_en) tck_d_reg <= pins_s.tck;
  end

  // the synchroniser restarts from zero while tck may idle high, so edges
  // are ignored until it holds real pin levels; otherwise reset fakes a rise
  logic [1:0] settle_reg;

  always_ff @(posedge mclk) begin
    if (reset) settle_reg <= '0;
    else if (clk_en && settle_reg != `TCK_SETTLE) settle_reg <= settle_reg + 2'h1;
  end

  wire settled  = (settle_reg == `TCK_SETTLE);
  wire tck_rise = clk_en & settled & pins_s.tck & ~tck_d_reg;
  wire tck_fall = clk_en & settled & ~pins_s.tck & tck_d_reg;
  wire tms      = pins_s.tms;
  wire tdi      = pins_s.tdi;

  // ----------------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------------
  tap_state_t state_reg, state_next;

  always_comb begin
    case (state_reg)
      st_reset:    state_next = tms ? st_reset    : st_idle;
      st_idle:     state_next = tms ? st_sel_dr   : st_idle;
      st_sel_dr:   state_next = tms ? st_sel_ir   : st_cap_dr;
      st_cap_dr:   state_next = tms ? st_exit1_dr : st_shift_dr;
      st_shift_dr: state_next = tms ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: state_next = tms ? st_upd_dr   : st_pause_dr;
      st_pause_dr: state_next = tms ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: state_next = tms ? st_upd_dr   : st_shift_dr;
      st_upd_dr:   state_next = tms ? st_sel_dr   : st_idle;
      st_sel_ir:   state_next = tms ? st_reset    : st_cap_ir;
      st_cap_ir:   state_next = tms ? st_exit1_ir : st_shift_ir;
      st_shift_ir: state_next = tms ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: state_next = tms ? st_upd_ir   : st_pause_ir;
      st_pause_ir: state_next = tms ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: state_next = tms ? st_upd_ir   : st_shift_ir;
      st_upd_ir:   state_next = tms ? st_sel_dr   : st_idle;
      default:     state_next = st_reset;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) state_reg <= st_reset;
    else if (tck_rise) state_reg <= state_next;
  end

  // ----------------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------------
  logic [`IR_W-1:0] ir_shift_reg;
  logic [`IR_W-1:0] ir_reg;

  // a power-up pulse on reset and the reset state both select idcode
  always_ff @(posedge mclk) begin
    if (reset) begin
      ir_shift_reg <= `IR_IDCODE;
      ir_reg       <= `IR_IDCODE;
    end else if (clk_en && state_reg == st_reset) begin
      ir_shift_reg <= `IR_IDCODE;
      ir_reg       <= `IR_IDCODE;
    end else begin
      if (tck_rise && state_reg == st_cap_ir) ir_shift_reg <= `IR_CAPTURE;
      if (tck_rise && state_reg == st_shift_ir)
        ir_shift_reg <= {tdi, ir_shift_reg[`IR_W-1:1]};
      // apart from reset and the reset state, the instruction only changes here, never in the dr branch
      if (tck_fall && state_reg == st_upd_ir) ir_reg <= ir_shift_reg;
    end
  end

  wire sel_chain  = (ir_reg == `IR_EXTEST) | (ir_reg == `IR_SAMPLE);
  wire sel_id     = (ir_reg == `IR_IDCODE);
  wire pins_owned = (ir_reg == `IR_EXTEST) | (ir_reg == `IR_CLAMP);

  // ----------------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------------
  logic [CHAIN_LEN-1:0] chain_reg;
  logic [CHAIN_LEN-1:0] chain_upd_reg;
  logic [`ID_W-1:0]     id_reg;
  logic                 pass_reg;

  wire dr_cap   = tck_rise && state_reg == st_cap_dr;
  wire dr_shift = tck_rise && state_reg == st_shift_dr;

  always_ff @(posedge mclk) begin
    if (reset) begin
      chain_reg <= '0;
      id_reg    <= '0;
      pass_reg  <= 1'b0;
    end else begin
      if (dr_cap && sel_chain) chain_reg <= obs_s;
      if (dr_shift && sel_chain) chain_reg <= {tdi, chain_reg[CHAIN_LEN-1:1]};
      if (dr_cap && sel_id) id_reg <= ID_VALUE;
      if (dr_shift && sel_id) id_reg <= {tdi, id_reg[`ID_W-1:1]};
      if (dr_cap && !sel_chain && !sel_id) pass_reg <= 1'b0;
      if (dr_shift && !sel_chain && !sel_id) pass_reg <= tdi;
    end
  end

  // parallel latch keeps pins steady while the shifter moves
  always_ff @(posedge mclk) begin
    if (reset) chain_upd_reg <= '0;
    else if (tck_fall && state_reg == st_upd_dr && sel_chain)
      chain_upd_reg <= chain_reg;
  end

  // only output-type cells may take over a pin; input cells just observe
  wire [CHAIN_LEN-1:0] out_mask = `OUT_CELL_MASK;
  wire owned_now = pins_owned && state_reg != st_reset;
  wire [CHAIN_LEN-1:0] drive_next =
    owned_now ? ((chain_upd_reg & out_mask) | (core_drive & ~out_mask)) : core_drive;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cell_drive  <= '0;
      test_active <= 1'b0;
    end else if (clk_en) begin
      cell_drive  <= drive_next;
      test_active <= owned_now;
    end
  end

  // ----------------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------------
  wire dr_out   = sel_chain ? chain_reg[0] : (sel_id ? id_reg[0] : pass_reg);
  wire shifting = state_reg == st_shift_dr || state_reg == st_shift_ir;
  wire tdo_next = (state_reg == st_shift_ir) ? ir_shift_reg[0] : dr_out;

  always_ff @(posedge mclk) begin
    if (reset) begin
      jtag_out.tdo      <= 1'b0;
      jtag_out.tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      jtag_out.tdo      <= shifting ? tdo_next : 1'b0;
      jtag_out.tdo_oe_n <= ~shifting;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [2:0] tms_ones_reg;
  always_ff @(posedge mclk) begin
    if (reset) tms_ones_reg <= '0;
    else if (tck_rise) tms_ones_reg <= !tms ? 3'h0 :
      (tms_ones_reg == `TMS_RESET_EDGES) ? tms_ones_reg : tms_ones_reg + 3'h1;
  end

  chk_tms_reset: assert property (
    tms_ones_reg == `TMS_RESET_EDGES |-> state_reg == st_reset)
    else $error("five tms-high edges did not reach reset state");
  chk_reset_idcode: assert property (
    clk_en && state_reg == st_reset |=> ir_reg == `IR_IDCODE)
    else $error("reset state did not select idcode");
  chk_idle_hold: assert property (
    state_reg == st_idle && tck_rise && !tms |=> state_reg == st_idle)
    else $error("idle left with tms low");
  chk_select_dr: assert property (
    state_reg == st_sel_dr && tck_rise
    |=> state_reg == ($past(tms) ? st_sel_ir : st_cap_dr))
    else $error("select-dr went to wrong state");
  chk_capture_pins: assert property (
    dr_cap && sel_chain |=> chain_reg == $past(obs_s))
    else $error("capture did not load pin levels");
  chk_capture_exit: assert property (
    state_reg == st_cap_dr && tck_rise
    |=> state_reg == ($past(tms) ? st_exit1_dr : st_shift_dr))
    else $error("capture-dr went to wrong state");
  chk_shift_path: assert property (
    dr_shift && sel_chain |=> chain_reg[CHAIN_LEN-1] == $past(tdi)
    && chain_reg[CHAIN_LEN-2:0] == $past(chain_reg[CHAIN_LEN-1:1]))
    else $error("chain did not shift one stage");
  chk_shift_exit: assert property (
    state_reg == st_shift_dr && tck_rise
    |=> state_reg == ($past(tms) ? st_exit1_dr : st_shift_dr))
    else $error("shift-dr went to wrong state");
  chk_ir_stable: assert property (
    state_reg inside {st_sel_dr, st_cap_dr, st_shift_dr} |=> $stable(ir_reg))
    else $error("instruction changed in dr scan");
  chk_pass_delay: assert property (
    dr_shift && !sel_chain && !sel_id |=> pass_reg == $past(tdi))
    else $error("passthrough bit did not follow tdi");
  chk_upd_only: assert property (!$stable(chain_upd_reg) |-> $past(state_reg) == st_upd_dr)
    else $error("chain outputs changed outside update-dr");
  chk_tdo_idle: assert property (tck_fall && !shifting |=> jtag_out.tdo_oe_n)
    else $error("tdo driven outside shift states");

  cov_shift_dr: cover property (dr_shift && sel_chain);
  cov_update_ir: cover property (tck_fall && state_reg == st_upd_ir);
  cov_tms_reset: cover property (state_reg == st_shift_dr ##[1:1000] state_reg == st_reset);
  cov_extest_drive: cover property (test_active && pins_owned);

endmodule

/* File: testbench/jtag_tester.sv */
/*
  Behavioural boundary-scan tester: makes tck (200 ns) only inside frames,
  drives tms/tdi and captures tdo. Assumes a 40 MHz mclk and that every
  task is entered on a rising mclk edge; each task ends on one.
*/
`timescale 1ns/100ps
module jtag_tester
  import tap_pkg::*;
(
  input  wire logic      mclk,      // bench clock, paces tck
  input  wire jtag_out_t jtag_out,  // tdo and its enable
  output jtag_in_t       jtag_in,   // tck, tms, tdi toward the device
  output logic           cap_valid, // one-mclk strobe per captured bit
  output logic           cap_bit    // captured tdo
);
  initial begin
    jtag_in   = '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
    cap_valid = 1'b0;
    cap_bit   = 1'b0;
  end

  always @(posedge mclk) cap_valid <= 1'b0;

  // ----------------------------------------------------------------------
  // one tck period = 8 mclk
  // ----------------------------------------------------------------------
  // tms/tdi move with the falling tck, so they sit 4 mclk before the rise
  task automatic cyc(input logic ms, input logic di);
    jtag_in.tck <= 1'b0;
    jtag_in.tms <= ms;
    jtag_in.tdi <= di;
    repeat (4) @(posedge mclk);
    jtag_in.tck <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    cap_bit   = jtag_out.tdo;
    cap_valid = ~jtag_out.tdo_oe_n;
    @(posedge mclk);
  endtask

  // data of no interest: inverse of the last bit, never a stale level
  task automatic nd(input logic ms);
    cyc(ms, ~jtag_in.tdi);
  endtask

  task automatic to_reset();
    repeat (5) nd(1'b1);
  endtask

  // ----------------------------------------------------------------------
  // scans start and end in run-test/idle
  // ----------------------------------------------------------------------
  task automatic ir_load(input logic [2:0] code);
    nd(1'b1);
    nd(1'b1);
    nd(1'b0);
    nd(1'b0);
    for (int i = 0; i < 3; i++) cyc(i == 2, code[i]);
    nd(1'b1);
    nd(1'b0);
  endtask

  // p >= 0 parks in pause-dr after bit p and comes back through exit2-dr
  task automatic dr_scan(input int n, input logic [76:0] d, input int p);
    nd(1'b1);
    nd(1'b0);
    nd(1'b0);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1 || i == p, d[i]);
      if (i == p) begin
        nd(1'b0);
        nd(1'b0);
        nd(1'b1);
        nd(1'b0);
      end
    end
    nd(1'b1);
    nd(1'b0);
  endtask
endmodule

/* File: testbench/jtag_tap_boundary_scan_tb_top.sv */
/*
  Self-checking bench for the test access port. Drivers note expected tdo
  bits and pin states in queues; a monitor compares them as they appear.
  Assumes jtag_tester stands on the far side of the tap pins.
*/
`timescale 1ns/100ps
`include "tap_regs.svh"
module jtag_tap_boundary_scan_tb_top
  import tap_pkg::*;
;
  localparam logic [31:0] ID_VAL = 32'h0a5c_3e71; // arbitrary value, bit 0 set
  localparam logic [76:0] OUT_M  = `OUT_CELL_MASK;
  localparam logic [2:0]  BYP_CODES [4] = '{`IR_BYPASS, 3'h5, 3'h4, 3'h6};

  logic        mclk, reset, clk_en, pin_chk, cap_valid, cap_bit, exp_bit, test_active;
  jtag_in_t    jtag_in;
  jtag_out_t   jtag_out;
  logic [76:0] cell_obs, core_drive, cell_drive, latch, d;
  logic [77:0] exp_pins;
  logic        bit_q [$];
  logic [77:0] pin_q [$];
  int          seed = 96863;
  int          n_errors = 0;
  int          tests_run = 0;

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

  jtag_tap_boundary_scan #(.ID_VALUE(ID_VAL))
    jtag_tap_boundary_scan_inst (.mclk(mclk), .reset(reset), .clk_en(clk_en),
    .jtag_in(jtag_in), .jtag_out(jtag_out), .cell_obs(cell_obs),
    .core_drive(core_drive), .cell_drive(cell_drive), .test_active(test_active));

  jtag_tester jtag_tester_inst (.mclk(mclk), .jtag_out(jtag_out), .jtag_in(jtag_in),
    .cap_valid(cap_valid), .cap_bit(cap_bit));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [76:0] rnd77();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return r[76:0];
  endfunction

  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic ir(input logic [2:0] code);
    bit_q.push_back(1'b1);
    bit_q.push_back(1'b0);
    bit_q.push_back(1'b0);
    jtag_tester_inst.ir_load(code);
  endtask

  // bypass-type paths capture 0 and return tdi one stage late
  task automatic scan(input int n, input logic [76:0] cap, input int p, input logic byp);
    d = rnd77();
    if (byp) cap = {d[75:0], 1'b0};
    for (int i = 0; i < n; i++) bit_q.push_back(cap[i]);
    jtag_tester_inst.dr_scan(n, d, p);
    if (!byp && n == `CHAIN_LEN) latch = d;
  endtask

  task automatic pins(input logic act);
    core_drive <= rnd77();
    repeat (3) @(posedge mclk);
    pin_q.push_back({act, act ? (core_drive & ~OUT_M) | (latch & OUT_M) : core_drive});
    pin_chk <= 1'b1;
    @(posedge mclk);
    pin_chk <= 1'b0;
  endtask

  task automatic obs();
    cell_obs <= rnd77();
    repeat (4) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (cap_valid) begin
      exp_bit = bit_q.size() > 0 ? bit_q.pop_front() : 1'bx;
      `CHK(cap_bit, exp_bit)
    end
    if (pin_chk) begin
      exp_pins = pin_q.size() > 0 ? pin_q.pop_front() : 'x;
      `CHK({test_active, cell_drive}, exp_pins)
    end
  end

  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    pin_chk = 1'b0;
    latch = '0;
    cell_obs = rnd77();
    core_drive = rnd77();
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(jtag_out, 2'b01)
    pins(1'b0);
    repeat (4) jtag_tester_inst.nd(1'b0);
    scan(32, 77'(ID_VAL), -1, 1'b0);
    ir(`IR_SAMPLE);
    obs();
    scan(77, cell_obs, 30, 1'b0);
    pins(1'b0);
    ir(`IR_EXTEST);
    pins(1'b1);
    obs();
    scan(77, cell_obs, -1, 1'b0);
    pins(1'b1);
    ir(`IR_CLAMP);
    scan(9, '0, 4, 1'b1);
    pins(1'b1);
    jtag_tester_inst.nd(1'b1);
    jtag_tester_inst.nd(1'b0);
    jtag_tester_inst.nd(1'b0);
    bit_q.push_back(1'b0);
    jtag_tester_inst.to_reset();
    pins(1'b0);
    jtag_tester_inst.nd(1'b0);
    scan(32, 77'(ID_VAL), -1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      ir(BYP_CODES[k]);
      scan(6, '0, 2, 1'b1);
      pins(1'b0);
    end
    // with the enable low the tap must ignore tck entirely
    clk_en <= 1'b0;
    jtag_tester_inst.nd(1'b1);
    jtag_tester_inst.nd(1'b1);
    clk_en <= 1'b1;
    @(posedge mclk);
    scan(6, '0, -1, 1'b1);
    jtag_tester_inst.nd(1'b1);
    jtag_tester_inst.nd(1'b0);
    jtag_tester_inst.nd(1'b0);
    bit_q.push_back(1'b0);
    jtag_tester_inst.nd(1'b0);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(jtag_out.tdo_oe_n, 1'b1)
    jtag_tester_inst.nd(1'b0);
    scan(32, 77'(ID_VAL), -1, 1'b0);
    `CHK(bit_q.size(), 0)
    end_of_test();
  end
endmodule
